// ==== inc/uef_pkg.sv ====
// shared constants and carrier types of the usb global event flag block
package uef_pkg;

  // register offsets on the special-function register port
  localparam logic [7:0] UEF_FLAGS_ADDR    = 8'hBD;
  localparam logic [7:0] UEF_ENABLES_ADDR  = 8'hBE;

  // reset values
  localparam logic [7:0] UEF_FLAGS_RESET   = 8'h00;
  localparam logic [7:0] UEF_ENABLES_RESET = 8'h10;

  // bit positions shared by the flag and enable registers
  localparam int UEF_BIT_WAKE      = 5;
  localparam int UEF_BIT_RESET_END = 4;
  localparam int UEF_BIT_FRAME     = 3;
  localparam int UEF_BIT_SUSPEND   = 0;

  // implemented bits; all others read as zero
  localparam logic [7:0] UEF_USED_MASK = 8'h39;

  // line states as {d_plus, d_minus}
  localparam logic [1:0] UEF_LINE_SE0 = 2'h0;
  localparam logic [1:0] UEF_LINE_J   = 2'h2;
  localparam logic [1:0] UEF_LINE_IDLE_RESET = 2'h2;

  // timing
  localparam longint UEF_CLK_HZ       = 64'd100_000_000;
  localparam longint UEF_FS_BIT_HZ    = 64'd12_000_000;
  localparam longint UEF_RESET_BITS   = 64'd32;
  localparam longint UEF_SUSPEND_MS   = 64'd3;
  // least time, rounded up
  localparam longint UEF_RESET_CYCLES =
    (UEF_RESET_BITS * UEF_CLK_HZ + UEF_FS_BIT_HZ - 64'd1) / UEF_FS_BIT_HZ;
  localparam longint UEF_SUSPEND_CYCLES = UEF_SUSPEND_MS * UEF_CLK_HZ / 64'd1000;

  // events reported by the line monitor; reset_end and suspend are one-cycle pulses, active is high in every cycle the line is not j
  typedef struct packed {
    logic reset_end;
    logic suspend;
    logic active;
  } uef_line_ev_type;

endpackage

// ==== rtl/uef_flags.sv ====
// usb global event flags, enables and shared usb interrupt
// Overview of operation
// - while suspended, bus activity not caused by own resume sets wake flag bit 5
// - wake flag drives the usb interrupt only when its enable is set
// - end of a detected bus reset sets reset-end flag bit 4
// - reset-end flag drives the interrupt only when its enable is set
// - each start-of-frame token sets frame-start flag bit 3
// - frame-start flag drives the interrupt only when its enable is set
// - flags stay set until software clears them; a new event wins over a clear
// - bus reset is single-ended zero for at least 32 full-speed bit times
module uef_flags #(
  parameter int RESET_CYCLES   = int'(uef_pkg::UEF_RESET_CYCLES),
  parameter int SUSPEND_CYCLES = int'(uef_pkg::UEF_SUSPEND_CYCLES)
) (
  // clock and reset
  input  wire logic       sys_clk_in,
  input  wire logic       rst_b_in,
  // register port
  input  wire logic [7:0] reg_addr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       reg_wr_in,
  input  wire logic       reg_rd_in,
  output logic      [7:0] reg_rdata_out,
  // usb lines and controller events
  input  wire logic       dp_in,
  input  wire logic       dm_in,
  input  wire logic       sof_pid_in,
  input  wire logic       upstream_resume_in,
  // status and interrupt
  output logic            suspended_out,
  output logic            usb_irq_out
);
  import uef_pkg::*;

  typedef struct packed {
    logic [7:0] flags;
    logic [7:0] enables;
    logic [7:0] rdata;
    logic       suspended;
    logic       irq;
  } uef_state_type;

  logic [1:0]      rst_sync_reg;
  logic            rst_b;
  uef_line_ev_type line_ev;
  uef_state_type   state_reg;
  uef_state_type   state_next;

  // reset release through two flops
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  assign rst_b = rst_sync_reg[1];

  uef_line_mon #(
    .RESET_CYCLES   (RESET_CYCLES),
    .SUSPEND_CYCLES (SUSPEND_CYCLES)
  ) u_line_mon (
    .clk_in   (sys_clk_in),
    .rst_b_in (rst_b),
    .dp_in    (dp_in),
    .dm_in    (dm_in),
    .ev_out   (line_ev)
  );

  function automatic logic [7:0] uef_bit(input int pos);
    uef_bit = 8'h01 << pos;
  endfunction

  logic [7:0] set_v;
  logic [7:0] clr_v;

  always_comb begin
    state_next       = state_reg;
    set_v            = 8'h00;
    clr_v            = 8'h00;
    state_next.rdata = 8'h00;
    // event sources
    if (state_reg.suspended && line_ev.active && !upstream_resume_in) begin
      set_v = set_v | uef_bit(UEF_BIT_WAKE);
    end
    if (line_ev.reset_end) begin
      set_v = set_v | uef_bit(UEF_BIT_RESET_END);
    end
    if (sof_pid_in) begin
      set_v = set_v | uef_bit(UEF_BIT_FRAME);
    end
    if (line_ev.suspend) begin
      set_v = set_v | uef_bit(UEF_BIT_SUSPEND);
    end
    // suspend state follows the bus
    if (line_ev.suspend) begin
      state_next.suspended = 1'b1;
    end else if (line_ev.active) begin
      state_next.suspended = 1'b0;
    end
    // register writes
    if (reg_wr_in && reg_addr_in == UEF_FLAGS_ADDR) begin
      clr_v = reg_wdata_in & UEF_USED_MASK;
    end
    if (reg_wr_in && reg_addr_in == UEF_ENABLES_ADDR) begin
      state_next.enables = reg_wdata_in & UEF_USED_MASK;
    end
    // set wins over a clear in the same cycle
    state_next.flags = ((state_reg.flags & ~clr_v) | set_v) & UEF_USED_MASK;
    // register reads, data valid in the next cycle only
    if (reg_rd_in && reg_addr_in == UEF_FLAGS_ADDR) begin
      state_next.rdata = state_reg.flags;
    end else if (reg_rd_in && reg_addr_in == UEF_ENABLES_ADDR) begin
      state_next.rdata = state_reg.enables;
    end
    // shared interrupt, each flag gated by its enable
    state_next.irq = |(state_next.flags & state_next.enables);
  end

  always_ff @(posedge sys_clk_in or negedge rst_b) begin
    if (!rst_b) begin
      state_reg         <= '0;
      state_reg.flags   <= UEF_FLAGS_RESET;
      state_reg.enables <= UEF_ENABLES_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign reg_rdata_out = state_reg.rdata;
  assign suspended_out = state_reg.suspended;
  assign usb_irq_out   = state_reg.irq;

endmodule

// ==== rtl/uef_line_mon.sv ====
// usb line monitor: pin synchroniser, bus reset and idle timers
module uef_line_mon #(
  parameter int RESET_CYCLES   = int'(uef_pkg::UEF_RESET_CYCLES),
  parameter int SUSPEND_CYCLES = int'(uef_pkg::UEF_SUSPEND_CYCLES)
) (
  // clock and reset
  input  wire logic                     clk_in,
  input  wire logic                     rst_b_in,
  // usb data lines
  input  wire logic                     dp_in,
  input  wire logic                     dm_in,
  // events
  output uef_pkg::uef_line_ev_type      ev_out
);
  import uef_pkg::*;

  localparam int SE0_W  = $clog2(RESET_CYCLES + 1);
  localparam int IDLE_W = $clog2(SUSPEND_CYCLES + 1);
  localparam logic [SE0_W-1:0]  SE0_LIMIT  = SE0_W'(RESET_CYCLES);
  localparam logic [IDLE_W-1:0] IDLE_LAST  = IDLE_W'(SUSPEND_CYCLES - 1);

  if (RESET_CYCLES < 1 || SUSPEND_CYCLES < 2) begin : g_bad
    $error("uef_line_mon: timing counts too small");
  end

  typedef struct packed {
    logic [1:0]        sync1;
    logic [1:0]        sync2;
    logic [1:0]        sync3;
    logic [1:0]        line;
    logic [SE0_W-1:0]  se0_cnt;
    logic [IDLE_W-1:0] idle_cnt;
    logic              susp_done;
    uef_line_ev_type   ev;
  } uef_mon_state_type;

  uef_mon_state_type state_reg;
  uef_mon_state_type state_next;

  always_comb begin
    state_next       = state_reg;
    state_next.ev    = '0;
    state_next.sync1 = {dp_in, dm_in};
    state_next.sync2 = state_reg.sync1;
    state_next.sync3 = state_reg.sync2;
    // accept a level once the last two stages agree
    if (state_reg.sync2 == state_reg.sync3) begin
      state_next.line = state_reg.sync3;
    end
    // single-ended zero length; end of a long one is end of reset
    if (state_reg.line == UEF_LINE_SE0) begin
      if (state_reg.se0_cnt != SE0_LIMIT) begin
        state_next.se0_cnt = state_reg.se0_cnt + 1'b1;
      end
    end else begin
      if (state_reg.se0_cnt == SE0_LIMIT) begin
        state_next.ev.reset_end = 1'b1;
      end
      state_next.se0_cnt = '0;
    end
    // idle time in j; any other line state is activity
    if (state_reg.line == UEF_LINE_J) begin
      if (state_reg.idle_cnt != IDLE_LAST) begin
        state_next.idle_cnt = state_reg.idle_cnt + 1'b1;
      end else if (!state_reg.susp_done) begin
        state_next.ev.suspend = 1'b1;
        state_next.susp_done  = 1'b1;
      end
    end else begin
      state_next.idle_cnt  = '0;
      state_next.susp_done = 1'b0;
      state_next.ev.active = 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_reg       <= '0;
      state_reg.sync1 <= UEF_LINE_IDLE_RESET;
      state_reg.sync2 <= UEF_LINE_IDLE_RESET;
      state_reg.sync3 <= UEF_LINE_IDLE_RESET;
      state_reg.line  <= UEF_LINE_IDLE_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign ev_out = state_reg.ev;

endmodule

// ==== verif/uef_flags_checker.sv ====
// assertion checker for the usb event flag block
module uef_flags_checker
  import uef_pkg::*;
#(
  parameter int RESET_CYCLES   = 8,
  parameter int SUSPEND_CYCLES = 200
) (
  // clock, reset, register port
  input wire logic       sys_clk_in,
  input wire logic       rst_b_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic       reg_wr_in,
  input wire logic       reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  // line, events, status
  input wire logic       dp_in,
  input wire logic       dm_in,
  input wire logic       sof_pid_in,
  input wire logic       upstream_resume_in,
  input wire logic       suspended_out,
  input wire logic       usb_irq_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic line_j;
  logic line_se0;
  int   j_cnt;
  int   se0_cnt;
  assign line_j   = dp_in & ~dm_in;
  assign line_se0 = ~dp_in & ~dm_in;
  // raw line-state run lengths
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      j_cnt   <= 0;
      se0_cnt <= 0;
    end else begin
      j_cnt   <= line_j ? j_cnt + 1 : 0;
      se0_cnt <= line_se0 ? se0_cnt + 1 : 0;
    end
  end
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);
  sequence s_sof_rd;
    sof_pid_in ##[1:2] (reg_rd_in && reg_addr_in == UEF_FLAGS_ADDR);
  endsequence
  AST_RSVD_ZERO: assert property (reg_rd_in |=> (reg_rdata_out & ~UEF_USED_MASK) == 8'h00)
    else $error("reserved flag bits read nonzero");
  AST_RD_IDLE: assert property (!reg_rd_in |=> reg_rdata_out == 8'h00)
    else $error("read data outside read cycle");
  AST_UNMAPPED: assert property (reg_rd_in && reg_addr_in != UEF_FLAGS_ADDR
    && reg_addr_in != UEF_ENABLES_ADDR |=> reg_rdata_out == 8'h00)
    else $error("unmapped read nonzero");
  AST_SOF_FLAG: assert property (s_sof_rd |=> reg_rdata_out[UEF_BIT_FRAME])
    else $error("frame flag not set after token");
  AST_IRQ_HOLD: assert property ($fell(usb_irq_out) |-> $past(reg_wr_in) || $past(reg_wr_in, 2))
    else $error("interrupt dropped without write");
  AST_SUSP_SET: assert property ($rose(suspended_out) |-> j_cnt >= SUSPEND_CYCLES)
    else $error("suspend before idle time");
  AST_SUSP_LEAVE: assert property ($fell(line_j) && suspended_out && !upstream_resume_in
    |-> ##[1:10] !suspended_out)
    else $error("suspend not left on activity");
  AST_RESET_END: assert property ($fell(line_se0) && se0_cnt >= RESET_CYCLES
    |-> ##[1:10] usb_irq_out)
    else $error("no interrupt at end of bus reset");
  AST_IRQ_MASKED: assert property (reg_wr_in && reg_addr_in == UEF_ENABLES_ADDR
    && reg_wdata_in == 8'h00 |-> ##2 !usb_irq_out)
    else $error("interrupt with all enables clear");
endmodule

bind uef_flags uef_flags_checker #(
  .RESET_CYCLES(RESET_CYCLES), .SUSPEND_CYCLES(SUSPEND_CYCLES)) u_chk (.*);

// ==== verif/uef_usb_host.sv ====
// full-speed host model driving the usb lines and frame tokens
module uef_usb_host (
  input  wire logic clk_in,
  output logic      dp_out,
  output logic      dm_out,
  output logic      sof_out
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    dp_out  = 1'b1;
    dm_out  = 1'b0;
    sof_out = 1'b0;
  end
  // hold a line state for about n cycles
  task automatic line(input logic [1:0] st, input int n);
    @(posedge clk_in);
    {dp_out, dm_out} <= st;
    repeat (n) @(posedge clk_in);
  endtask
  task automatic sof();
    @(posedge clk_in);
    sof_out <= 1'b1;
    @(posedge clk_in);
    sof_out <= 1'b0;
  endtask
endmodule

// ==== verif/usb_global_event_flags_tb.sv ====
// self-checking bench for the usb event flag block
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("unexpected %s exp %h got %h", nm, e, g); end end
module usb_global_event_flags_tb;
  import uef_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int RC = 8;
  localparam int SC = 200;
  localparam logic [1:0] K = 2'h1;
  logic       clk, rst_b, wr, rd, res, dp, dm, sof, susp, irq;
  logic [7:0] addr, wdata, rdata;
  int         n_mismatch, num_checks;
  uef_usb_host host (.clk_in(clk), .dp_out(dp), .dm_out(dm), .sof_out(sof));
  uef_flags #(.RESET_CYCLES(RC), .SUSPEND_CYCLES(SC)) dut (
    .sys_clk_in(clk), .rst_b_in(rst_b), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .dp_in(dp), .dm_in(dm),
    .sof_pid_in(sof), .upstream_resume_in(res), .suspended_out(susp), .usb_irq_out(irq));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input string nm);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 `CHK(nm, e, rdata)
  endtask
  task automatic irq_chk(input logic e);
    #1 `CHK("irq", e, irq)
  endtask
  task automatic t_regs();
    rd_chk(UEF_FLAGS_ADDR, 8'h00, "flags");
    rd_chk(UEF_ENABLES_ADDR, 8'h10, "enables");
    rd_chk(8'hBC, 8'h00, "unmapped");
    wr_reg(8'hBC, 8'h39);
    rd_chk(UEF_ENABLES_ADDR, 8'h10, "unmapped write");
    irq_chk(1'b0);
    $display("test regs done");
  endtask
  task automatic t_sof();
    wr_reg(UEF_ENABLES_ADDR, 8'h08);
    host.sof();
    rd_chk(UEF_FLAGS_ADDR, 8'h08, "frame flag");
    irq_chk(1'b1);
    wr_reg(UEF_ENABLES_ADDR, 8'h00);
    repeat (2) @(posedge clk);
    irq_chk(1'b0);
    rd_chk(UEF_FLAGS_ADDR, 8'h08, "flag kept");
    wr_reg(UEF_FLAGS_ADDR, 8'h08);
    rd_chk(UEF_FLAGS_ADDR, 8'h00, "flag cleared");
    wr_reg(UEF_ENABLES_ADDR, 8'h39);
    rd_chk(UEF_ENABLES_ADDR, 8'h39, "enable bits");
    $display("test sof done");
  endtask
  task automatic t_reset();
    wr_reg(UEF_ENABLES_ADDR, 8'h10);
    host.line(UEF_LINE_SE0, RC / 2);
    host.line(UEF_LINE_J, 10);
    rd_chk(UEF_FLAGS_ADDR, 8'h00, "short se0");
    host.line(UEF_LINE_SE0, RC + 4);
    host.line(UEF_LINE_J, 10);
    rd_chk(UEF_FLAGS_ADDR, 8'h10, "reset end");
    irq_chk(1'b1);
    wr_reg(UEF_FLAGS_ADDR, 8'h10);
    $display("test bus reset done");
  endtask
  task automatic t_suspend();
    wr_reg(UEF_ENABLES_ADDR, 8'h21);
    host.line(UEF_LINE_J, SC + 10);
    `CHK("suspended", 1'b1, susp)
    rd_chk(UEF_FLAGS_ADDR, 8'h01, "suspend flag");
    irq_chk(1'b1);
    wr_reg(UEF_FLAGS_ADDR, 8'h01);
    host.line(K, 3);
    host.line(UEF_LINE_J, 10);
    `CHK("suspended", 1'b0, susp)
    rd_chk(UEF_FLAGS_ADDR, 8'h20, "wake flag");
    irq_chk(1'b1);
    wr_reg(UEF_ENABLES_ADDR, 8'h01);
    repeat (2) @(posedge clk);
    irq_chk(1'b0);
    wr_reg(UEF_FLAGS_ADDR, 8'h20);
    host.line(UEF_LINE_J, SC + 10);
    res <= 1'b1;
    host.line(K, 3);
    host.line(UEF_LINE_J, 10);
    res <= 1'b0;
    rd_chk(UEF_FLAGS_ADDR, 8'h01, "own resume");
    $display("test suspend done");
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    #100us;
    n_mismatch++;
    test_done();
  end
  initial begin
    {rst_b, wr, rd, res, addr, wdata} = '0;
    n_mismatch = 0;
    num_checks = 0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs();
    t_sof();
    t_reset();
    t_suspend();
    test_done();
  end
endmodule
